// ### hdl/i2p_device.sv
// Device end: two-wire target reaching an 8-bit register store
`timescale 1ns/1ps
module i2p_device (
  input  wire logic   clk_i,
  input  wire logic   reset_i,
  i2p_if.device       bus,
  input  wire logic [7:0] rd_data_i,   // Register contents at reg_addr_o
  output logic [7:0]  reg_addr_o,
  output logic [7:0]  wr_data_o,
  output logic        wr_stb_o,        // One-cycle write pulse
  output logic        rd_stb_o,        // One-cycle pulse when a byte is fetched
  output logic        busy_o
);
  typedef struct packed {
    i2p_pkg::i2p_dev_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       rw;        // Direction of the current address phase
    logic       have_ptr;  // Register address already received
    logic       ack_mode;  // Ack phase after address (1) or data (0)
    logic       step;      // Data byte taken, pointer moves at ack end
    logic       sda_low;
    logic       busy;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } i2p_dev_t;

  i2p_dev_t r;
  i2p_dev_t next_r;
  logic     scl_h;
  logic     scl_rise;
  logic     scl_fall;
  logic     sda_h;
  logic     sda_rise;
  logic     sda_fall;

  ////////////////////////////////////////////////////////////////////////////
  // Line synchronisers
  i2p_sync u_scl (.clk_i(clk_i), .reset_i(reset_i), .line_i(bus.scl),
                  .level_o(scl_h), .rise_o(scl_rise), .fall_o(scl_fall));
  i2p_sync u_sda (.clk_i(clk_i), .reset_i(reset_i), .line_i(bus.sda),
                  .level_o(sda_h), .rise_o(sda_rise), .fall_o(sda_fall));

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine
  always_comb
  begin
    next_r        = r;
    next_r.wr_stb = 1'b0;
    next_r.rd_stb = 1'b0;
    if (scl_h && sda_fall)
    begin
      // Start or repeated start, also from mid-transfer
      next_r.st      = i2p_pkg::I2P_ADDR;
      next_r.cnt     = i2p_pkg::I2P_RST_CNT;
      next_r.sda_low = 1'b0;
      next_r.busy    = 1'b1;
      next_r.step    = 1'b0;
    end
    else if (scl_h && sda_rise)
    begin
      // Stop, or a glitch mid-byte; both end the transaction
      next_r.st       = i2p_pkg::I2P_IDLE;
      next_r.sda_low  = 1'b0;
      next_r.have_ptr = 1'b0;
      next_r.busy     = 1'b0;
    end
    else
    begin
      case (r.st)
        i2p_pkg::I2P_ADDR, i2p_pkg::I2P_RECV:
        begin
          if (scl_rise)
          begin
            next_r.sh  = {r.sh[6:0], sda_h};
            next_r.cnt = r.cnt + 4'h1;
          end
          else if (scl_fall && r.cnt == i2p_pkg::I2P_BITS)
          begin
            next_r.cnt = i2p_pkg::I2P_RST_CNT;
            if (r.st == i2p_pkg::I2P_ADDR)
            begin
              if (r.sh[7:1] == i2p_pkg::I2P_DEV_ADDR)
              begin
                next_r.rw       = r.sh[0];
                // A write phase always opens with a fresh register address
                next_r.have_ptr = r.have_ptr & r.sh[0];
                next_r.ack_mode = 1'b1;
                next_r.sda_low  = 1'b1;
                next_r.st       = i2p_pkg::I2P_ACK;
              end
              else
              begin
                next_r.st   = i2p_pkg::I2P_WAIT;
              end
            end
            else
            begin
              if (!r.have_ptr)
              begin
                next_r.addr     = r.sh;
                next_r.have_ptr = 1'b1;
              end
              else
              begin
                next_r.wdata  = r.sh;
                next_r.wr_stb = 1'b1;
                next_r.step   = 1'b1;
              end
              next_r.ack_mode = 1'b0;
              next_r.sda_low  = 1'b1;
              next_r.st       = i2p_pkg::I2P_ACK;
            end
          end
        end
        i2p_pkg::I2P_ACK:
        begin
          // Hold low through the ninth high phase; after its fall release, or after a read address drive the first data bit
          if (scl_fall)
          begin
            next_r.sda_low = 1'b0;
            if (r.ack_mode && r.rw)
            begin
              next_r.st      = i2p_pkg::I2P_SEND;
              next_r.sh      = rd_data_i;
              next_r.rd_stb  = 1'b1;
              next_r.sda_low = ~rd_data_i[7];
              next_r.cnt     = 4'h1;
            end
            else
            begin
              // Advance only after the write pulse has used the old address
              if (r.step)
              begin
                next_r.addr = r.addr + 8'h01;
              end
              next_r.step = 1'b0;
              next_r.st   = i2p_pkg::I2P_RECV;
            end
          end
        end
        i2p_pkg::I2P_SEND:
        begin
          if (scl_fall)
          begin
            if (r.cnt == i2p_pkg::I2P_BITS)
            begin
              next_r.sda_low = 1'b0;
              next_r.st      = i2p_pkg::I2P_RACK;
            end
            else
            begin
              next_r.sh      = {r.sh[6:0], 1'b0};
              next_r.sda_low = ~r.sh[6];
              next_r.cnt     = r.cnt + 4'h1;
            end
          end
        end
        i2p_pkg::I2P_RACK:
        begin
          if (scl_rise)
          begin
            if (sda_h)
            begin
              next_r.st = i2p_pkg::I2P_WAIT;
            end
            else
            begin
              next_r.addr = r.addr + 8'h01;
              next_r.cnt  = i2p_pkg::I2P_RST_CNT;
            end
          end
          else if (scl_fall && r.cnt == i2p_pkg::I2P_RST_CNT)
          begin
            next_r.st      = i2p_pkg::I2P_SEND;
            next_r.sh      = rd_data_i;
            next_r.rd_stb  = 1'b1;
            next_r.sda_low = ~rd_data_i[7];
            next_r.cnt     = 4'h1;
          end
        end
        default:
        begin
          next_r.sda_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r <= '0;
    end
    else
    begin
      r <= next_r;
    end
  end

  // Open-drain data only; the clock line is never driven
  assign bus.d_sda_o    = 1'b0;
  assign bus.d_sda_oe_n = ~r.sda_low;
  assign reg_addr_o     = r.addr;
  assign wr_data_o      = r.wdata;
  assign wr_stb_o       = r.wr_stb;
  assign rd_stb_o       = r.rd_stb;
  assign busy_o         = r.busy;
endmodule

// ### hdl/i2p_pkg.sv
// Shared constants and types for the two-wire register port
package i2p_pkg;
  localparam logic [6:0] I2P_DEV_ADDR   = 7'h2d;  // 8-bit form 5a write, 5b read
  localparam logic [3:0] I2P_BITS       = 4'h8;
  localparam logic [3:0] I2P_ACK_BIT    = 4'h8;   // Ninth pulse index from zero
  localparam int         I2P_CLK_MHZ    = 50;
  localparam int         I2P_HALF_NS    = 2500;   // Host half period, 200 kHz bus
  localparam logic [7:0] I2P_HALF_CYC   = 8'((I2P_HALF_NS * I2P_CLK_MHZ) / 1000);
  localparam logic [7:0] I2P_RST_DATA   = 8'h00;
  localparam logic [7:0] I2P_RST_ADDR   = 8'h00;
  localparam logic [1:0] I2P_SYNC_RST   = 2'h3;   // Idle bus level is high
  localparam logic [3:0] I2P_RST_CNT    = 4'h0;

  // Device end phases
  typedef enum logic [2:0] {
    I2P_IDLE  = 3'h0,
    I2P_ADDR  = 3'h1,
    I2P_ACK   = 3'h3,
    I2P_RECV  = 3'h2,
    I2P_SEND  = 3'h6,
    I2P_RACK  = 3'h7,
    I2P_WAIT  = 3'h5
  } i2p_dev_state_t;

  // Host end phases
  typedef enum logic [2:0] {
    I2P_H_IDLE  = 3'h0,
    I2P_H_START = 3'h1,
    I2P_H_BIT   = 3'h3,
    I2P_H_STOP  = 3'h2,
    I2P_H_DONE  = 3'h6
  } i2p_host_state_t;
endpackage

// ### hdl/i2p_if.sv
// Two-wire bus between host and device, with open-drain resolution
`timescale 1ns/1ps
interface i2p_if;
  logic scl_o;      // Host clock drive value
  logic scl_oe_n;   // Host clock enable, low drives
  logic h_sda_o;
  logic h_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic scl;
  logic sda;

  // Wired-and with pullups
  assign scl = scl_oe_n | scl_o;
  assign sda = (h_sda_oe_n | h_sda_o) & (d_sda_oe_n | d_sda_o);

  modport host (output scl_o, output scl_oe_n, output h_sda_o, output h_sda_oe_n,
                input scl, input sda);
  modport device (output d_sda_o, output d_sda_oe_n, input scl, input sda);
endinterface

// ### hdl/i2p_sync.sv
// Two-stage synchroniser with edge detection for the bus lines
`timescale 1ns/1ps
module i2p_sync (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic line_i,
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);
  typedef struct packed {
    logic [1:0] stage;
    logic       last;
  } i2p_sync_t;

  i2p_sync_t r;
  i2p_sync_t next_r;

  // First stage feeds only the second; edges come from the second onward
  always_comb
  begin
    next_r       = r;
    next_r.stage = {r.stage[0], line_i};
    next_r.last  = r.stage[1];
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      r <= '{stage: i2p_pkg::I2P_SYNC_RST, last: 1'b1};
    end
    else
    begin
      r <= next_r;
    end
  end

  assign level_o = r.last;
  assign rise_o  = r.stage[1] & ~r.last;
  assign fall_o  = ~r.stage[1] & r.last;
endmodule

// ### bench/i2p_asserts.sv
// Concurrent checks on how the device end drives the two-wire bus
`timescale 1ns/1ps
module i2p_asserts (
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic scl,
  input  wire logic sda,
  input  wire logic d_sda_o,
  input  wire logic d_sda_oe_n
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  ////////////////////////////////////////////////////////////////////////////////
  // Host made bus conditions, clock held high on both sides of the data edge
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // Device drive moves only in the low clock phase
  chk_high_stable: assert property (scl && $past(scl) |-> $stable(d_sda_oe_n))
    else $error("device data moved while clock high");
  chk_drive_low_phase: assert property ($fell(d_sda_oe_n) |-> !scl)
    else $error("device drive began while clock high");
  chk_release_low: assert property ($rose(d_sda_oe_n) |-> !scl)
    else $error("device release while clock high");
  // A pull lasts across the following high phase
  chk_ack_hold: assert property ($fell(d_sda_oe_n) |-> ##1 (!d_sda_oe_n) [*5])
    else $error("device pull too short");
  // Open drain: enabled means low on the wire
  chk_pull_level: assert property (!d_sda_oe_n |-> !d_sda_o && !sda)
    else $error("device drove data high");
  chk_start_quiet: assert property (s_start |=> d_sda_oe_n [*8])
    else $error("device drove data after start");
  chk_stop_idle: assert property (s_stop |=> d_sda_oe_n [*8])
    else $error("device drove data after stop");
  chk_reset_idle: assert property ($past(reset_i) |-> d_sda_oe_n)
    else $error("device drove data out of reset");
endmodule

// ### bench/tb.sv
// Bench playing the host on the two-wire bus against the device end
`timescale 1ns/1ps
module tb;
  logic       clk_i;
  logic       reset_i;
  logic [7:0] rd_data_i;
  logic [7:0] reg_addr_o;
  logic [7:0] wr_data_o;
  logic       wr_stb_o;
  logic       rd_stb_o;
  logic       busy_o;
  logic       bit_seen;
  int         rd_fetches = 0;
  logic [7:0] mem [0:15];
  int         err_total = 0;
  int         compares  = 0;
  int         cycles    = 0;

  i2p_if bus ();
  i2p_device i2p_device_inst (.clk_i(clk_i), .reset_i(reset_i), .bus(bus),
    .rd_data_i(rd_data_i), .reg_addr_o(reg_addr_o), .wr_data_o(wr_data_o),
    .wr_stb_o(wr_stb_o), .rd_stb_o(rd_stb_o), .busy_o(busy_o));
  i2p_asserts i2p_asserts_inst (.clk_i(clk_i), .reset_i(reset_i), .scl(bus.scl),
    .sda(bus.sda), .d_sda_o(bus.d_sda_o), .d_sda_oe_n(bus.d_sda_oe_n));
  assign rd_data_i = mem[reg_addr_o[3:0]];
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  // Register store, and a hang limit far above the whole run
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (wr_stb_o)
      mem[reg_addr_o[3:0]] <= wr_data_o;
    if (rd_stb_o)
      rd_fetches <= rd_fetches + 1;
    if (cycles == 8000)
    begin
      err_total = err_total + 1;
      give_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    compares = compares + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One bus clock of 8 cycles, data set mid low and sampled mid high
  task automatic put_bit(input logic b, output logic r);
    tick(2);
    bus.h_sda_oe_n <= b;
    tick(2);
    bus.scl_oe_n <= 1'b1;
    tick(2);
    r = bus.sda;
    tick(2);
    bus.scl_oe_n <= 1'b0;
  endtask
  task automatic put_byte(input logic [7:0] v, input logic ack_in, output logic [7:0] d,
                          output logic ack);
    for (int i = 7; i >= 0; i--)
      put_bit(v[i], d[i]);
    put_bit(ack_in, ack);
  endtask
  // Works from idle and as a repeated start from a low clock
  task automatic start();
    tick(2);
    bus.h_sda_oe_n <= 1'b1;
    tick(2);
    bus.scl_oe_n <= 1'b1;
    tick(4);
    bus.h_sda_oe_n <= 1'b0;
    tick(4);
    bus.scl_oe_n <= 1'b0;
  endtask
  task automatic stop();
    tick(2);
    bus.h_sda_oe_n <= 1'b0;
    tick(2);
    bus.scl_oe_n <= 1'b1;
    tick(4);
    bus.h_sda_oe_n <= 1'b1;
    tick(8);
  endtask
  // Start, then address byte with a chosen address and direction, ack checked
  task automatic head(input logic [6:0] adr, input logic dir, input logic exp_ack);
    logic [7:0] d;
    logic       a;
    start();
    check("busy start", {7'h00, busy_o}, 8'h01);
    put_byte({adr, dir}, 1'b1, d, a);
    check("addr ack", {7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic wr_byte(input logic [7:0] v, input logic exp_ack);
    logic [7:0] d;
    logic       a;
    put_byte(v, 1'b1, d, a);
    check("byte ack", {7'h00, a}, {7'h00, exp_ack});
  endtask
  task automatic rd_byte(input logic host_ack, input logic [7:0] exp);
    logic [7:0] d;
    logic       a;
    put_byte(8'hff, host_ack, d, a);
    check("read data", d, exp);
  endtask
  task automatic give_verdict();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    reset_i = 1'b1;
    bus.scl_o = 1'b0;
    bus.scl_oe_n = 1'b1;
    bus.h_sda_o = 1'b0;
    bus.h_sda_oe_n = 1'b1;
    foreach (mem[i])
      mem[i] = 8'h00;
    tick(3);
    reset_i <= 1'b0;
    tick(4);
    // Two data bytes in one write, pointer advancing
    head(i2p_pkg::I2P_DEV_ADDR, 1'b0, 1'b0);
    wr_byte(8'h03, 1'b0);
    wr_byte(8'ha5, 1'b0);
    wr_byte(8'h3c, 1'b0);
    stop();
    check("reg3", mem[3], 8'ha5);
    check("reg4", mem[4], 8'h3c);
    check("busy", {7'h00, busy_o}, 8'h00);
    // Pointer write, repeated start, two reads, last one refused
    head(i2p_pkg::I2P_DEV_ADDR, 1'b0, 1'b0);
    wr_byte(8'h03, 1'b0);
    head(i2p_pkg::I2P_DEV_ADDR, 1'b1, 1'b0);
    rd_byte(1'b0, 8'ha5);
    rd_byte(1'b1, 8'h3c);
    stop();
    check("fetches", 8'(rd_fetches), 8'h02);
    // Foreign address stays silent throughout
    head(i2p_pkg::I2P_DEV_ADDR ^ 7'h01, 1'b0, 1'b1);
    wr_byte(8'h05, 1'b1);
    wr_byte(8'h77, 1'b1);
    stop();
    check("reg5", mem[5], 8'h00);
    // Stop in mid data byte drops the write
    head(i2p_pkg::I2P_DEV_ADDR, 1'b0, 1'b0);
    wr_byte(8'h07, 1'b0);
    repeat (4)
      put_bit(1'b0, bit_seen);
    stop();
    check("reg7", mem[7], 8'h00);
    head(i2p_pkg::I2P_DEV_ADDR, 1'b0, 1'b0);
    wr_byte(8'h08, 1'b0);
    wr_byte(8'hc3, 1'b0);
    stop();
    check("reg8", mem[8], 8'hc3);
    give_verdict();
  end
endmodule
